// >>> rtl/bio_bus_options.v
`timescale 1ns/1ns
`include "bio_defines.vh"

module bio_bus_options #(
	parameter ADDR_W = 8,
	parameter LEN_W = 16,
	parameter CNT_W = 16
) (
	clk,
	rst_n,
	sw_rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	link_active_enable,
	quad_rd,
	quad_data,
	quad_valid,
	rx_wr_valid,
	rx_wr_len,
	ack_type_err,
	max_rec_bytes
);
	input wire clk;
	input wire rst_n;
	input wire sw_rst;
	input wire [ADDR_W-1:0] reg_addr;
	input wire [31:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output wire [31:0] reg_rdata;
	input wire link_active_enable;
	input wire quad_rd;
	output wire [31:0] quad_data;
	output wire quad_valid;
	input wire rx_wr_valid;
	input wire [LEN_W-1:0] rx_wr_len;
	output wire ack_type_err;
	output wire [16:0] max_rec_bytes;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [4:0] cap_ff;
	reg [7:0] acc_ff;
	reg [3:0] rec_ff;
	reg chg_ff;
	reg [CNT_W-1:0] err_cnt_ff;
	reg [31:0] rdata_ff;
	reg [31:0] quad_ff;
	reg quad_vld_ff;

	reg [4:0] nxt_cap;
	reg [7:0] nxt_acc;
	reg [3:0] nxt_rec;
	reg nxt_chg;
	reg [CNT_W-1:0] nxt_err_cnt;
	reg [31:0] nxt_rdata;

	wire [31:0] opt_word;
	wire [31:0] stat_word;
	wire wr_opt;
	wire wr_stat;
	wire err_pulse;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function hit;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	assign wr_opt = reg_wr && hit(reg_addr, `BIO_OFF_OPTIONS);
	assign wr_stat = reg_wr && hit(reg_addr, `BIO_OFF_STATUS);

	// ----------------------------------------
	// assembled words
	// ----------------------------------------
	// generation counter bits 7..6 are not held here and read as zero
	assign opt_word = {cap_ff,
		3'h0,
		acc_ff,
		rec_ff,
		4'h0,
		5'h00,
		`BIO_LNK_SPD};

	assign stat_word = {err_cnt_ff[15:0], 13'h0000, chg_ff,
		(rec_ff >= `BIO_REC_MIN), link_active_enable};

	// ----------------------------------------
	// register next values
	// ----------------------------------------
	always @* begin
		nxt_cap = cap_ff;
		nxt_acc = acc_ff;
		nxt_rec = rec_ff;
		if (wr_opt) begin
			nxt_cap = reg_wdata[`BIO_CAP_MSB:`BIO_CAP_LSB];
			nxt_acc = reg_wdata[`BIO_ACC_MSB:`BIO_ACC_LSB];
			nxt_rec = reg_wdata[`BIO_REC_MSB:`BIO_REC_LSB];
		end
		// soft reset clears all but the exponent
		if (sw_rst) begin
			nxt_cap = `BIO_CAP_RST;
			nxt_acc = `BIO_ACC_RST;
		end
	end

	// catches software changing fields under a running link
	always @* begin
		nxt_chg = chg_ff;
		if (wr_stat && reg_wdata[`BIO_ST_CHG])
			nxt_chg = 1'b0;
		if (wr_opt && link_active_enable)
			nxt_chg = 1'b1;
	end

	always @* begin
		nxt_err_cnt = err_cnt_ff;
		if (wr_stat && reg_wdata[`BIO_ST_CNT_CLR])
			nxt_err_cnt = {CNT_W{1'b0}};
		// a new error in the clearing cycle still counts
		if (err_pulse) begin
			if (wr_stat && reg_wdata[`BIO_ST_CNT_CLR])
				nxt_err_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
			else if (err_cnt_ff != {CNT_W{1'b1}})
				nxt_err_cnt = err_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// unmapped reads answer zero
	always @* begin
		nxt_rdata = 32'h00000000;
		if (reg_rd && hit(reg_addr, `BIO_OFF_OPTIONS))
			nxt_rdata = opt_word;
		else if (reg_rd && hit(reg_addr, `BIO_OFF_STATUS))
			nxt_rdata = stat_word;
	end

	// ----------------------------------------
	// flops
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_ff <= `BIO_CAP_RST;
			acc_ff <= `BIO_ACC_RST;
			rec_ff <= `BIO_REC_RST;
			chg_ff <= 1'b0;
			err_cnt_ff <= {CNT_W{1'b0}};
			rdata_ff <= 32'h00000000;
			quad_ff <= 32'h00000000;
			quad_vld_ff <= 1'b0;
		end else begin
			cap_ff <= nxt_cap;
			acc_ff <= nxt_acc;
			rec_ff <= nxt_rec;
			chg_ff <= nxt_chg;
			err_cnt_ff <= nxt_err_cnt;
			rdata_ff <= nxt_rdata;
			quad_vld_ff <= quad_rd;
			if (quad_rd)
				quad_ff <= opt_word;
		end
	end

	// ----------------------------------------
	// received write length check
	// ----------------------------------------
	bio_len_check #(
		.LEN_W(LEN_W)
	) u_len_check (
		.clk(clk),
		.rst_n(rst_n),
		.max_rec(rec_ff),
		.pkt_valid(rx_wr_valid),
		.pkt_len(rx_wr_len),
		.ack_type_err(err_pulse),
		.rec_bytes(max_rec_bytes)
	);

	assign ack_type_err = err_pulse;
	assign reg_rdata = rdata_ff;
	assign quad_data = quad_ff;
	assign quad_valid = quad_vld_ff;
endmodule

// >>> rtl/bio_defines.vh
// Notes on behaviour
// - bits 31 to 28 are four writable capability flags that read back as written and reset to 0.
// - bit 27 is a writable power-management capability flag that resets to 0.
// - bits 26 to 24 always read as zero and ignore writes.
// - bits 23 to 16 hold a writable clock accuracy value in ppm that resets to zero.
// - bits 15 to 12 hold the request size exponent, the byte limit being 2 to the power exponent plus one; below 512 it applies but status bit 1 reads 0.
// - hardware reset loads the exponent with a (2048 bytes) and a software reset leaves it alone.
// - software may rewrite the exponent and the new value becomes the advertised limit.
// - a received block write longer than the byte limit may be answered with a type-error acknowledge.
// - bits 2 to 0 always read as binary 010.
// - bits 11 to 8 always read as zero.
`ifndef BIO_DEFINES_VH
`define BIO_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BIO_OFF_OPTIONS 8'h20
`define BIO_OFF_STATUS 8'h40

// ----------------------------------------
// options word fields
// ----------------------------------------
`define BIO_CAP_MSB 31
`define BIO_CAP_LSB 27
`define BIO_ACC_MSB 23
`define BIO_ACC_LSB 16
`define BIO_REC_MSB 15
`define BIO_REC_LSB 12
`define BIO_LNK_SPD 3'h2

// ----------------------------------------
// status word fields
// ----------------------------------------
`define BIO_ST_LINKED 0
`define BIO_ST_REC_OK 1
`define BIO_ST_CHG 2
`define BIO_ST_CNT_CLR 3
`define BIO_ST_CNT_LSB 16

// ----------------------------------------
// reset values
// ----------------------------------------
`define BIO_CAP_RST 5'h00
`define BIO_ACC_RST 8'h00
`define BIO_REC_RST 4'ha
`define BIO_REC_MIN 4'h8
`define BIO_REC_BYTES_RST 17'h00800

`endif

// >>> rtl/bio_len_check.v
`timescale 1ns/1ns
`include "bio_defines.vh"

module bio_len_check #(
	parameter LEN_W = 16
) (
	clk,
	rst_n,
	max_rec,
	pkt_valid,
	pkt_len,
	ack_type_err,
	rec_bytes
);
	input wire clk;
	input wire rst_n;
	input wire [3:0] max_rec;
	input wire pkt_valid;
	input wire [LEN_W-1:0] pkt_len;
	output wire ack_type_err;
	output wire [16:0] rec_bytes;

	reg ack_type_err_ff;
	reg [16:0] rec_bytes_ff;
	reg [16:0] nxt_rec_bytes;
	reg nxt_ack_type_err;

	// both sides padded to one common width so the compare never truncates
	localparam CMP_W = (LEN_W > 17) ? LEN_W : 17;

	// ----------------------------------------
	// byte limit from the exponent
	// ----------------------------------------
	always @* begin
		nxt_rec_bytes = 17'h00001 << ({1'b0, max_rec} + 5'h01);
		// compare against the limit in force when the packet arrives
		nxt_ack_type_err = pkt_valid &&
			({{(CMP_W + 1 - LEN_W){1'b0}}, pkt_len} >
			{{(CMP_W - 16){1'b0}}, rec_bytes_ff});
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rec_bytes_ff <= `BIO_REC_BYTES_RST;
			ack_type_err_ff <= 1'b0;
		end else begin
			rec_bytes_ff <= nxt_rec_bytes;
			ack_type_err_ff <= nxt_ack_type_err;
		end
	end

	assign ack_type_err = ack_type_err_ff;
	assign rec_bytes = rec_bytes_ff;
endmodule

// >>> tb/bio_props.sv
`timescale 1ns/1ns
// ----
// options checker
// ----
module bio_props #(
	parameter ADDR_W = 8,
	parameter LEN_W = 16
) (
	input logic clk,
	input logic rst_n,
	input logic sw_rst,
	input logic [ADDR_W-1:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [31:0] reg_rdata,
	input logic quad_rd,
	input logic [31:0] quad_data,
	input logic quad_valid,
	input logic rx_wr_valid,
	input logic [LEN_W-1:0] rx_wr_len,
	input logic ack_type_err,
	input logic [16:0] max_rec_bytes
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_RRD: assert property (
		reg_rd && reg_addr == 8'h20 |=> (reg_rdata & 32'h07000fff) == 32'h2)
		else $error("bad fixed read bits");
	AST_QFX: assert property (
		quad_valid |-> (quad_data & 32'h07000fff) == 32'h2)
		else $error("bad fixed quadlet bits");
	AST_QV: assert property (quad_rd |=> quad_valid)
		else $error("quadlet not answered");
	AST_WR: assert property (
		reg_wr && reg_addr == 8'h20 && !sw_rst ##1 quad_rd && !reg_wr
		|=> quad_data[31:12] == ($past(reg_wdata[31:12], 2) & 20'hf8fff))
		else $error("write not seen in quadlet");
	AST_SW: assert property (
		sw_rst && !reg_wr |=> ##1 $stable(max_rec_bytes))
		else $error("soft reset moved exponent");
	AST_ACK: assert property (
		$past(rst_n) |-> ack_type_err ==
		$past(rx_wr_valid && rx_wr_len > max_rec_bytes))
		else $error("bad length ack");
	AST_BYT: assert property (
		quad_valid |-> max_rec_bytes == 17'h1 << (quad_data[15:12] + 5'h1))
		else $error("byte limit off");
	AST_RST: assert property (
		$rose(rst_n) |-> max_rec_bytes == 17'h00800 && quad_data == 32'h0)
		else $error("bad reset state");
endmodule

// >>> tb/bio_host_ctl.sv
`timescale 1ns/1ns
// ----
// host controller link enable
// ----
module bio_host_ctl (
	input logic clk,
	input logic rst_n,
	input logic cfg_done,
	output logic link_active_enable
);
	logic link_en_ff;
	// link goes up only once software says its fields are loaded
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			link_en_ff <= 1'b0;
		else if (cfg_done)
			link_en_ff <= 1'b1;
	assign link_active_enable = link_en_ff;
endmodule

// >>> tb/test_bio_bus_options.sv
`timescale 1ns/1ns
// ----
// bench top
// ----
module test_bio_bus_options;
	logic clk, rst_n, sw_rst, wr, rd, qrd, rxv, cfg_done, lae, qv, ack;
	logic pr, pa;
	logic [7:0] addr;
	logic [31:0] wd, rdata, qdata, d, cur;
	logic [15:0] rxl, lim;
	logic [16:0] mrb;
	logic [31:0] exp_r[$], exp_q[$];
	logic exp_a[$];
	int num_errors, tests_run, cyc, seed, i;
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	bio_bus_options dut (.clk, .rst_n, .sw_rst, .reg_addr(addr),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.link_active_enable(lae), .quad_rd(qrd), .quad_data(qdata),
		.quad_valid(qv), .rx_wr_valid(rxv), .rx_wr_len(rxl),
		.ack_type_err(ack), .max_rec_bytes(mrb));
	bio_host_ctl host (.clk, .rst_n, .cfg_done, .link_active_enable(lae));
	task chk_w(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task chk_a(input logic g, input logic e);
		chk_w({31'h0, g}, {31'h0, e});
	endtask
	task reg_w(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task reg_r(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		exp_r.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task quad(input logic [31:0] e);
		qrd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		qrd <= 1'b0;
	endtask
	task rx(input logic [15:0] l, input logic e);
		rxv <= 1'b1;
		rxl <= l;
		exp_a.push_back(e);
		@(posedge clk);
		rxv <= 1'b0;
	endtask
	task wrap_up;
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		pr <= rd;
		pa <= rxv;
		if (pr)
			chk_w(rdata, exp_r.pop_front());
		if (qv)
			chk_w(qdata, exp_q.pop_front());
		if (pa)
			chk_a(ack, exp_a.pop_front());
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		seed = 43571;
		{rst_n, sw_rst, wr, rd, qrd, rxv, cfg_done} = 7'h0;
		addr = 8'h00;
		wd = 32'h0;
		rxl = 16'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		reg_r(8'h20, 32'h0000a002);
		quad(32'h0000a002);
		rx(16'h0800, 1'b0);
		@(posedge clk);
		rx(16'h0801, 1'b1);
		for (i = 0; i < 6; i++) begin
			d = $random(seed) & 32'hffffbfff;
			cur = d & 32'hf8fff000 | 32'h2;
			lim = 16'h1 << (cur[15:12] + 5'h1);
			reg_w(8'h20, d);
			quad(cur);
			reg_r(8'h20, cur);
			rx(lim, 1'b0);
			@(posedge clk);
			rx(lim + 16'h1, 1'b1);
		end
		cfg_done <= 1'b1;
		sw_rst <= 1'b1;
		@(posedge clk);
		sw_rst <= 1'b0;
		quad(cur & 32'h0000f00f);
		reg_w(8'h20, cur);
		reg_r(8'h40, 32'h00070005 | {30'h0, cur[15], 1'b0});
		reg_w(8'h40, 32'h0000000c);
		reg_r(8'h40, 32'h00000001 | {30'h0, cur[15], 1'b0});
		reg_r(8'h24, 32'h00000000);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		reg_r(8'h20, 32'h0000a002);
		repeat (3) @(posedge clk);
		wrap_up();
	end
endmodule
bind bio_bus_options bio_props #(.ADDR_W(ADDR_W), .LEN_W(LEN_W)) props (
	.clk, .rst_n, .sw_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .quad_rd, .quad_data, .quad_valid, .rx_wr_valid,
	.rx_wr_len, .ack_type_err, .max_rec_bytes);
